// ### rtl/latch_skip_exec.sv
// decode and execute of latch read, latch write and test-zero-skip
module latch_skip_exec (
    input wire logic clk,                   // core clock, 25 MHz
    input wire logic rst,                   // async reset, active high
    input wire logic ce,                    // clock enable, freezes all state
    input wire logic [1:0] phase,           // phase of instruction cycle, 0..3
    input wire logic instr_valid,           // instr holds an instruction to execute
    input wire logic [15:0] instr,          // instruction word
    input wire logic [7:0] file_rdata,      // file register read data
    output logic [7:0] file_addr,           // file register address
    output logic file_re,                   // file read strobe, phase two
    output logic file_we,                   // file write strobe, phase four
    output logic [7:0] file_wdata,          // file write data
    output logic flush,                     // discard prefetched instruction
    output logic [15:0] table_latch_out,    // table latch contents
    output logic busy_skip                  // skip pending, high from the test's fourth phase through the decode phase of the forced no-op
);
    typedef enum logic [1:0] {OP_NONE, OP_LREAD, OP_LWRITE, OP_TEST} op_t;

    op_t op_reg, op_next;
    logic [7:0] addr_reg, addr_next;
    logic sel_reg, sel_next;
    logic [7:0] src_reg, src_next;
    logic re_reg, re_next;
    logic we_reg, we_next;
    logic [7:0] wdata_reg, wdata_next;
    logic flush_reg, flush_next;
    logic skip_reg, skip_next;
    logic load_hi, load_lo;
    logic [7:0] latch_hi, latch_lo;
    op_t dec_op;

    // opcode decode
    always_comb begin
        dec_op = OP_NONE;
        if (instr[15:10] == latch_skip_pkg::LATCH_READ_OP) begin
            dec_op = OP_LREAD;
        end else if (instr[15:10] == latch_skip_pkg::LATCH_WRITE_OP) begin
            dec_op = OP_LWRITE;
        end else if (instr[15:8] == latch_skip_pkg::TEST_SKIP_OP) begin
            dec_op = OP_TEST;
        end
    end

    // phase sequencing: decode at phase 0, read at 1, act at 2, latch load at 3
    always_comb begin
        op_next = op_reg;
        addr_next = addr_reg;
        sel_next = sel_reg;
        src_next = src_reg;
        re_next = 1'b0;
        we_next = 1'b0;
        wdata_next = wdata_reg;
        flush_next = 1'b0;
        skip_next = skip_reg;
        load_hi = 1'b0;
        load_lo = 1'b0;
        unique case (phase)
            latch_skip_pkg::PHASE_DECODE: begin
                if (skip_reg) begin
                    op_next = OP_NONE; // forced no-op replaces prefetched word
                    skip_next = 1'b0;
                end else begin
                    op_next = instr_valid ? dec_op : OP_NONE;
                    addr_next = instr[7:0];
                    sel_next = instr[latch_skip_pkg::SEL_BIT];
                    re_next = instr_valid && (dec_op == OP_LWRITE || dec_op == OP_TEST);
                end
            end
            latch_skip_pkg::PHASE_READ: begin
                // source read in second phase
                if (op_reg == OP_LREAD) begin
                    src_next = sel_reg ? latch_hi : latch_lo;
                end else if (op_reg != OP_NONE) begin
                    src_next = file_rdata;
                end
            end
            latch_skip_pkg::PHASE_EXEC: begin
                // stage file write so it shows during phase four
                if (op_reg == OP_LREAD) begin
                    we_next = 1'b1;
                    wdata_next = src_reg;
                end else if (op_reg == OP_TEST && src_reg == 8'h00) begin
                    flush_next = 1'b1;
                    skip_next = 1'b1;
                end
            end
            latch_skip_pkg::PHASE_WRITE: begin
                // latch byte write in fourth phase, no flags touched
                if (op_reg == OP_LWRITE) begin
                    load_hi = sel_reg;
                    load_lo = !sel_reg;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_reg <= OP_NONE;
            addr_reg <= 8'h00;
            sel_reg <= 1'b0;
            src_reg <= 8'h00;
            re_reg <= 1'b0;
            we_reg <= 1'b0;
            wdata_reg <= 8'h00;
            flush_reg <= 1'b0;
            skip_reg <= 1'b0;
        end else if (ce) begin
            op_reg <= op_next;
            addr_reg <= addr_next;
            sel_reg <= sel_next;
            src_reg <= src_next;
            re_reg <= re_next;
            we_reg <= we_next;
            wdata_reg <= wdata_next;
            flush_reg <= flush_next;
            skip_reg <= skip_next;
        end
    end

    // latch halves
    latch_byte #(.WIDTH(latch_skip_pkg::DATA_W)) u_hi (
        .clk(clk), .rst(rst), .ce(ce), .load(load_hi), .din(src_reg), .dout(latch_hi)
    );
    latch_byte #(.WIDTH(latch_skip_pkg::DATA_W)) u_lo (
        .clk(clk), .rst(rst), .ce(ce), .load(load_lo), .din(src_reg), .dout(latch_lo)
    );

    assign file_addr = addr_reg;
    assign file_re = re_reg;
    assign file_we = we_reg;
    assign file_wdata = wdata_reg;
    assign flush = flush_reg;
    assign busy_skip = skip_reg;
    assign table_latch_out = {latch_hi, latch_lo};

    // assertions
    property p_read_hi;
        @(posedge clk) disable iff (rst)
        (ce && phase == 2'h1 && op_reg == OP_LREAD && sel_reg) |=> (src_reg == $past(latch_hi));
    endproperty
    a_read_hi: assert property (p_read_hi) else $error("latch read high byte wrong");

    property p_read_keeps_latch;
        @(posedge clk) disable iff (rst)
        (ce && op_reg == OP_LREAD) |=> $stable(table_latch_out);
    endproperty
    a_read_keeps_latch: assert property (p_read_keeps_latch) else $error("latch changed on read");

    property p_write_phase;
        @(posedge clk) disable iff (rst)
        file_we |-> (phase == latch_skip_pkg::PHASE_WRITE || !ce);
    endproperty
    a_write_phase: assert property (p_write_phase) else $error("file write outside phase four");

    property p_lwrite_hi;
        @(posedge clk) disable iff (rst)
        (ce && phase == 2'h3 && op_reg == OP_LWRITE && sel_reg)
            |=> (latch_hi == $past(src_reg) && latch_lo == $past(latch_lo));
    endproperty
    a_lwrite_hi: assert property (p_lwrite_hi) else $error("latch high load wrong");

    property p_lwrite_lo;
        @(posedge clk) disable iff (rst)
        (ce && phase == 2'h3 && op_reg == OP_LWRITE && !sel_reg)
            |=> (latch_lo == $past(src_reg) && latch_hi == $past(latch_hi));
    endproperty
    a_lwrite_lo: assert property (p_lwrite_lo) else $error("latch low load wrong");

    property p_skip_zero;
        @(posedge clk) disable iff (rst)
        (ce && phase == 2'h2 && op_reg == OP_TEST && src_reg == 8'h00 && !skip_reg) |=> (flush && busy_skip);
    endproperty
    a_skip_zero: assert property (p_skip_zero) else $error("zero test did not flush");

    property p_no_skip_nonzero;
        @(posedge clk) disable iff (rst)
        (ce && phase == 2'h2 && op_reg == OP_TEST && src_reg != 8'h00) |=> !flush;
    endproperty
    a_no_skip_nonzero: assert property (p_no_skip_nonzero) else $error("nonzero test flushed");

    property p_test_no_write;
        @(posedge clk) disable iff (rst)
        (op_reg == OP_TEST || op_reg == OP_LWRITE) |-> !file_we;
    endproperty
    a_test_no_write: assert property (p_test_no_write) else $error("unexpected file write");

    property p_read_writes_file;
        @(posedge clk) disable iff (rst)
        (ce && phase == 2'h2 && op_reg == OP_LREAD) |=> (file_we && file_wdata == $past(src_reg));
    endproperty
    a_read_writes_file: assert property (p_read_writes_file) else $error("latch read lost");

    property p_re_phase;
        @(posedge clk) disable iff (rst)
        file_re |-> (phase == latch_skip_pkg::PHASE_READ || !ce);
    endproperty
    a_re_phase: assert property (p_re_phase) else $error("file read outside phase two");

    property p_freeze;
        @(posedge clk) disable iff (rst)
        !ce |=> ($stable(table_latch_out) && $stable(file_we) && $stable(flush) && $stable(busy_skip));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

    property p_skip_clears;
        @(posedge clk) disable iff (rst)
        (ce && phase == latch_skip_pkg::PHASE_DECODE && skip_reg) |=> (!busy_skip && !file_re);
    endproperty
    a_skip_clears: assert property (p_skip_clears) else $error("forced no-op not ended");

    property p_flush_one;
        @(posedge clk) disable iff (rst)
        (ce && flush) |=> !flush;
    endproperty
    a_flush_one: assert property (p_flush_one) else $error("flush longer than one cycle");

    c_lread: cover property (@(posedge clk) disable iff (rst) op_reg == OP_LREAD && file_we);
    c_lwrite: cover property (@(posedge clk) disable iff (rst) load_hi || load_lo);
    c_skip: cover property (@(posedge clk) disable iff (rst) flush);
    c_noskip: cover property (@(posedge clk) disable iff (rst) op_reg == OP_TEST && phase == 2'h3 && !busy_skip);
    c_frozen: cover property (@(posedge clk) disable iff (rst) !ce && phase == 2'h0);
endmodule

// ### rtl/latch_skip_pkg.sv
// constants shared by the table latch and test-skip decoder
// Contract
// - opcode 1010 00tx copies one latch byte into file register in one cycle
// - latch read takes high byte when t is 1, low byte when t is 0
// - latch read leaves latch and status flags untouched; only file register written
// - opcode 1010 01tx stores file register into one latch byte, one cycle, no flags
// - latch write loads high byte when t is 1, low byte otherwise; other byte holds
// - opcode 0011 0011 with address is test-zero-skip; no status flags altered
// - tested register zero discards prefetched instruction, forced no-op, two cycles
package latch_skip_pkg;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;
    // opcode high byte patterns, compared on bits 15:10 for latch ops
    localparam logic [5:0] LATCH_READ_OP = 6'h28;   // 1010 00
    localparam logic [5:0] LATCH_WRITE_OP = 6'h29;  // 1010 01
    localparam logic [7:0] TEST_SKIP_OP = 8'h33;    // 0011 0011
    localparam int SEL_BIT = 9;                     // t bit position
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam logic [1:0] PHASE_DECODE = 2'h0;     // first phase
    localparam logic [1:0] PHASE_READ = 2'h1;       // second phase
    localparam logic [1:0] PHASE_EXEC = 2'h2;       // third phase
    localparam logic [1:0] PHASE_WRITE = 2'h3;      // fourth phase
endpackage

// ### rtl/latch_byte.sv
// one byte of the table latch with its own load enable
module latch_byte #(
    parameter int WIDTH = 8
) (
    input wire logic clk,              // core clock
    input wire logic rst,              // async reset
    input wire logic ce,               // clock enable
    input wire logic load,             // load strobe
    input wire logic [WIDTH-1:0] din,  // new byte
    output logic [WIDTH-1:0] dout      // held byte
);
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    // a byte half needs at least one bit
    if (WIDTH < 1) begin : g_width_check
        $error("latch byte width must be positive");
    end

    // hold unless loaded
    always_comb begin
        q_next = load ? din : q_reg;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_reg <= '0;
        end else if (ce) begin
            q_reg <= q_next;
        end
    end

    assign dout = q_reg;
endmodule

// ### sim/file_mem_model.sv
// behavioural data-memory file on the far side of the decoder
module file_mem_model (
    input wire logic clk,          // core clock
    input wire logic [7:0] addr,   // file address
    input wire logic re,           // read strobe
    input wire logic we,           // write strobe
    input wire logic [7:0] wdata,  // write data
    output logic [7:0] rdata       // read data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    // data only valid while the read strobe is up, inverted junk otherwise
    assign rdata = re ? mem[addr] : ~last;
    // capture destination writes in the fourth phase
    always @(posedge clk) begin
        if (re) last <= mem[addr];
        if (we) mem[addr] <= wdata;
    end
endmodule

// ### sim/table_latch_and_test_skip_exec_tb.sv
// testbench for latch read, latch write and test-zero-skip execution
module table_latch_and_test_skip_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, ce, instr_valid, file_re, file_we, flush, busy_skip;
    logic [1:0] phase;
    logic [15:0] instr, table_latch_out;
    logic [7:0] file_rdata, file_addr, file_wdata;
    logic re_seen, we_seen, fl_seen, bs_seen;
    logic [7:0] addr_seen, wd_seen;
    int errors, total_checks;
    latch_skip_exec latch_skip_exec_inst (.clk(clk), .rst(rst), .ce(ce), .phase(phase),
        .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata), .file_addr(file_addr),
        .file_re(file_re), .file_we(file_we), .file_wdata(file_wdata), .flush(flush),
        .table_latch_out(table_latch_out), .busy_skip(busy_skip));
    file_mem_model file_mem_model_inst (.clk(clk), .addr(file_addr), .re(file_re), .we(file_we),
        .wdata(file_wdata), .rdata(file_rdata));
    // 25 MHz core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // value compare
    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one four-phase instruction cycle, strobes sampled in their phase
    task run_instr(input logic [15:0] word);
        for (int p = 0; p < 4; p++) begin
            @(negedge clk);
            phase = p[1:0];
            instr_valid = (p == 0);
            instr = (p == 0) ? word : 16'h0000;
            if (p == 1) begin
                re_seen = file_re;
                addr_seen = file_addr;
            end
            if (p == 3) begin
                we_seen = file_we;
                wd_seen = file_wdata;
                fl_seen = flush;
                bs_seen = busy_skip;
            end
        end
        @(posedge clk);
        #1;
    endtask
    // latch write high then low, other byte kept
    task t_latch_write;
        file_mem_model_inst.mem[8'h10] = 8'hB7;
        file_mem_model_inst.mem[8'h11] = 8'h5A;
        run_instr(16'hA610);
        chk({15'h0000, re_seen}, 16'h0001, "src read phase");
        chk({8'h00, addr_seen}, 16'h0010, "file address");
        chk(table_latch_out, 16'hB700, "latch high");
        run_instr(16'hA511);
        chk(table_latch_out, 16'hB75A, "latch low");
        $display("test latch_write done");
    endtask
    // latch read high then low, latch untouched
    task t_latch_read;
        file_mem_model_inst.mem[8'h20] = 8'h00;
        file_mem_model_inst.mem[8'h21] = 8'h00;
        run_instr(16'hA220);
        chk({15'h0000, we_seen}, 16'h0001, "dest write phase");
        chk({8'h00, wd_seen}, 16'h00B7, "dest write data");
        chk({8'h00, file_mem_model_inst.mem[8'h20]}, 16'h00B7, "read high");
        run_instr(16'hA021);
        chk({8'h00, file_mem_model_inst.mem[8'h21]}, 16'h005A, "read low");
        chk(table_latch_out, 16'hB75A, "latch kept");
        $display("test latch_read done");
    endtask
    // zero skips the next word, non-zero does not
    task t_skip;
        file_mem_model_inst.mem[8'h30] = 8'h00;
        file_mem_model_inst.mem[8'h31] = 8'h01;
        run_instr(16'h3330);
        chk({14'h0000, fl_seen, bs_seen}, 16'h0003, "skip flush");
        run_instr(16'hA631);
        chk(table_latch_out, 16'hB75A, "skipped write");
        run_instr(16'h3331);
        chk({14'h0000, fl_seen, bs_seen}, 16'h0000, "no skip");
        run_instr(16'hA631);
        chk(table_latch_out, 16'h015A, "next executes");
        $display("test skip done");
    endtask
    // an instruction offered with clock enable low is not taken
    task t_freeze;
        file_mem_model_inst.mem[8'h12] = 8'h3C;
        @(negedge clk);
        ce = 1'b0;
        phase = 2'h0;
        instr_valid = 1'b1;
        instr = 16'hA412;
        @(negedge clk);
        chk({15'h0000, file_re}, 16'h0000, "frozen decode");
        chk(table_latch_out, 16'h015A, "frozen latch");
        ce = 1'b1;
        instr_valid = 1'b0;
        instr = 16'h0000;
        run_instr(16'hA412);
        chk(table_latch_out, 16'h013C, "after freeze");
        $display("test freeze done");
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        phase = 2'h0;
        instr_valid = 1'b0;
        instr = 16'h0000;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk(table_latch_out, 16'h0000, "latch reset");
        t_latch_write();
        t_latch_read();
        t_skip();
        t_freeze();
        print_verdict();
    end
    // watchdog
    initial begin
        #(40 * 400);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
